// ===== design/can_msg_ctrl.sv
// message control logic for two can message objects, each reached
// through one interface control register over avalon-mm.
// assumes the message handler gives one-cycle event pulses on clk and
// an avalon master that holds its request until waitrequest is low.
//
// Contract
// - length codes 0..8 mean that many bytes
// - length codes 9..15 mean eight bytes
// - stored data frame overwrites the length code
// - end-of-buffer flag marks fifo chain end
// - transmit request reads one while sending pends
// - remote reply enable sets transmit request
// - receive irq enable sets pending on reception
// - transmit irq enable sets pending on transmission
// - pending object reported by interrupt identifier
// - invalid objects are ignored by handler
`timescale 1ns/1ns
`default_nettype none

module can_msg_ctrl (
  input wire logic clk, // 50 mhz system clock
  input wire logic rst_b, // synchronous reset, active low
  input wire logic [31:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // write byte lanes
  output logic [31:0] avs_readdata, // read data, registered
  output logic avs_waitrequest, // stall, combinational
  input wire can_msg_ctrl_pkg::hnd_evt_t evt, // message handler events
  output logic [1:0] tx_pending, // object waits to transmit
  output logic [1:0] rx_accept, // object may take frames
  output logic [1:0] eob_flags, // end-of-buffer per object
  output logic [7:0] payload_bytes, // byte counts, object 1 high nibble
  output logic [1:0] obj_irq_id, // 0 none, else pending object plus one
  output logic irq // level interrupt
);

  // bus handshake state
  logic ack; // answer cycle of a request
  logic req; // read or write present
  logic rd_take; // read completes this edge
  logic wr_take; // write completes this edge
  logic [31:0] rd_word; // read mux result
  logic [31:0] be_mask; // byte lanes as bit mask

  // message object state
  can_msg_ctrl_pkg::obj_ctrl_t ctrl [can_msg_ctrl_pkg::NUM_OBJ]; // object control
  can_msg_ctrl_pkg::obj_ctrl_t next_ctrl [can_msg_ctrl_pkg::NUM_OBJ]; // next control
  logic [can_msg_ctrl_pkg::NUM_OBJ-1:0] valid; // object valid bits
  logic [can_msg_ctrl_pkg::NUM_OBJ-1:0] ctrl_hit; // write hits an object register
  logic [can_msg_ctrl_pkg::NUM_OBJ-1:0] evt_hit; // event targets a valid object

  // interrupt state
  logic [can_msg_ctrl_pkg::NUM_EVT-1:0] sts; // sticky events
  logic [can_msg_ctrl_pkg::NUM_EVT-1:0] mask; // event enables
  logic [can_msg_ctrl_pkg::NUM_EVT-1:0] sts_set; // events this cycle
  logic [1:0] next_irq_id; // identifier from next pending bits

  // request decode
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack;
  assign rd_take = avs_read & ack;
  assign wr_take = avs_write & ack;
  assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign ctrl_hit[0] = wr_take && (avs_address == can_msg_ctrl_pkg::IF1_CTRL_ADDR);
  assign ctrl_hit[1] = wr_take && (avs_address == can_msg_ctrl_pkg::IF2_CTRL_ADDR);

  // handler events only reach valid objects
  assign evt_hit[0] = valid[0] && (evt.obj == 1'b0);
  assign evt_hit[1] = valid[1] && (evt.obj == 1'b1);

  // one wait cycle per request, then answer
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack;
    end
  end

  // read mux, unmapped addresses read zero
  always_comb begin
    unique case (avs_address)
      can_msg_ctrl_pkg::IF1_CTRL_ADDR: rd_word = can_msg_ctrl_pkg::ctrl_to_word(ctrl[0]);
      can_msg_ctrl_pkg::IF2_CTRL_ADDR: rd_word = can_msg_ctrl_pkg::ctrl_to_word(ctrl[1]);
      can_msg_ctrl_pkg::VALID_ADDR: rd_word = {30'h0000_0000, valid};
      can_msg_ctrl_pkg::IRQ_STATUS_ADDR: rd_word = {29'h0000_0000, sts};
      can_msg_ctrl_pkg::IRQ_MASK_ADDR: rd_word = {29'h0000_0000, mask};
      can_msg_ctrl_pkg::IRQ_ID_ADDR: rd_word = {30'h0000_0000, obj_irq_id};
      default: rd_word = can_msg_ctrl_pkg::WORD_ZERO;
    endcase
  end

  // read data captured in the wait cycle, stands through the answer
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      avs_readdata <= can_msg_ctrl_pkg::WORD_ZERO;
    end else if (avs_read && !ack) begin
      avs_readdata <= rd_word;
    end
  end

  // next control per object: software write, then handler events win
  always_comb begin
    for (int i = 0; i < can_msg_ctrl_pkg::NUM_OBJ; i++) begin
      next_ctrl[i] = ctrl[i];
      // software write with byte lanes
      if (ctrl_hit[i]) begin
        next_ctrl[i] = can_msg_ctrl_pkg::word_to_ctrl(
          (can_msg_ctrl_pkg::ctrl_to_word(ctrl[i]) & ~be_mask) | (avs_writedata & be_mask));
      end
      // stored data frame
      if (evt_hit[i] && evt.rx_data) begin
        next_ctrl[i].data_length_code = evt.dlc;
        if (ctrl[i].receive_irq_enable) begin
          next_ctrl[i].object_irq_pending = 1'b1;
        end
      end
      // successful transmission
      if (evt_hit[i] && evt.tx_done) begin
        next_ctrl[i].transmit_request = 1'b0;
        if (ctrl[i].transmit_irq_enable) begin
          next_ctrl[i].object_irq_pending = 1'b1;
        end
      end
      // remote frame answer, set beats any clear
      if (evt_hit[i] && evt.rx_remote && ctrl[i].remote_reply_enable) begin
        next_ctrl[i].transmit_request = 1'b1;
      end
    end
  end

  // object control registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < can_msg_ctrl_pkg::NUM_OBJ; i++) begin
        ctrl[i] <= can_msg_ctrl_pkg::CTRL_RESET;
      end
    end else begin
      for (int i = 0; i < can_msg_ctrl_pkg::NUM_OBJ; i++) begin
        ctrl[i] <= next_ctrl[i];
      end
    end
  end

  // object valid register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      valid <= can_msg_ctrl_pkg::VALID_RESET;
    end else if (wr_take && (avs_address == can_msg_ctrl_pkg::VALID_ADDR)
                 && avs_byteenable[0]) begin
      valid <= avs_writedata[can_msg_ctrl_pkg::NUM_OBJ-1:0];
    end
  end

  // per-object outputs from flops
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      payload_bytes <= 8'h00;
      eob_flags <= 2'h0;
    end else begin
      // decode capped at eight bytes
      payload_bytes <= {can_msg_ctrl_pkg::payload_of(next_ctrl[1].data_length_code),
                        can_msg_ctrl_pkg::payload_of(next_ctrl[0].data_length_code)};
      eob_flags <= {next_ctrl[1].end_of_buffer_flag,
                    next_ctrl[0].end_of_buffer_flag};
    end
  end

  // handler facing levels
  assign tx_pending = {ctrl[1].transmit_request & valid[1],
                       ctrl[0].transmit_request & valid[0]};
  assign rx_accept = valid;

  // identifier: lowest object number has highest priority
  always_comb begin
    if (next_ctrl[0].object_irq_pending) begin
      next_irq_id = 2'h1;
    end else if (next_ctrl[1].object_irq_pending) begin
      next_irq_id = 2'h2;
    end else begin
      next_irq_id = 2'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      obj_irq_id <= 2'h0;
    end else begin
      obj_irq_id <= next_irq_id;
    end
  end

  // event sources for the status register
  assign sts_set[can_msg_ctrl_pkg::EVT_RX] = |evt_hit && evt.rx_data;
  assign sts_set[can_msg_ctrl_pkg::EVT_TX] = |evt_hit && evt.tx_done;
  assign sts_set[can_msg_ctrl_pkg::EVT_RMT] = |evt_hit && evt.rx_remote
    && ((evt_hit[0] && ctrl[0].remote_reply_enable)
        || (evt_hit[1] && ctrl[1].remote_reply_enable));

  // sticky status, write one clears, a new event wins over the clear
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sts <= can_msg_ctrl_pkg::EVT_RESET;
    end else if (wr_take && (avs_address == can_msg_ctrl_pkg::IRQ_STATUS_ADDR)
                 && avs_byteenable[0]) begin
      sts <= (sts & ~avs_writedata[can_msg_ctrl_pkg::NUM_EVT-1:0]) | sts_set;
    end else begin
      sts <= sts | sts_set;
    end
  end

  // interrupt mask
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mask <= can_msg_ctrl_pkg::EVT_RESET;
    end else if (wr_take && (avs_address == can_msg_ctrl_pkg::IRQ_MASK_ADDR)
                 && avs_byteenable[0]) begin
      mask <= avs_writedata[can_msg_ctrl_pkg::NUM_EVT-1:0];
    end
  end

  // level interrupt from flops
  assign irq = |(sts & mask);

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // short codes decode to themselves
  AST_PAYLOAD_SHORT: assert property (
    ctrl[0].data_length_code <= can_msg_ctrl_pkg::MAX_BYTES
      |-> payload_bytes[3:0] == ctrl[0].data_length_code)
    else $error("payload count wrong for short length code");

  // long codes cap at eight
  AST_PAYLOAD_CAP: assert property (
    ctrl[1].data_length_code > can_msg_ctrl_pkg::MAX_BYTES
      |-> payload_bytes[7:4] == can_msg_ctrl_pkg::MAX_BYTES)
    else $error("payload count not capped at eight");

  // stored frame length lands in the object
  AST_RX_DLC: assert property (
    evt_hit[0] && evt.rx_data |=> ctrl[0].data_length_code == $past(evt.dlc))
    else $error("received length code not stored");

  // a pending transmission stays pending and shown until sent or rewritten
  AST_TX_PENDING: assert property (
    valid[1] && ctrl[1].transmit_request && !(evt_hit[1] && evt.tx_done) && !ctrl_hit[1]
      |=> ctrl[1].transmit_request && (tx_pending[1] || !valid[1]))
    else $error("transmit request not shown as pending");

  // remote frame with reply enabled requests transmission
  AST_REMOTE_SET: assert property (
    evt_hit[1] && evt.rx_remote && ctrl[1].remote_reply_enable
      |=> ctrl[1].transmit_request ##1 tx_pending[1] || !valid[1] || $fell(ctrl[1].transmit_request))
    else $error("remote frame did not set transmit request");

  // remote frame without reply enabled leaves request alone
  AST_REMOTE_HOLD: assert property (
    evt_hit[1] && evt.rx_remote && !ctrl[1].remote_reply_enable && !evt.tx_done && !ctrl_hit[1]
      |=> $stable(ctrl[1].transmit_request))
    else $error("remote frame changed transmit request while disabled");

  // reception with enable raises pending and the identifier
  AST_RX_PEND: assert property (
    evt_hit[0] && evt.rx_data && ctrl[0].receive_irq_enable
      |=> ctrl[0].object_irq_pending && obj_irq_id == 2'h1)
    else $error("reception did not raise pending");

  // transmission clears the request and, if enabled, raises pending
  AST_TX_DONE: assert property (
    evt_hit[1] && evt.tx_done && !evt.rx_remote
      |=> !ctrl[1].transmit_request
          && (ctrl[1].object_irq_pending || !$past(ctrl[1].transmit_irq_enable)))
    else $error("transmission did not clear request or raise pending");

  // object 1 reported whenever it pends while object 0 is quiet
  AST_IRQ_PRIO: assert property (
    ctrl[1].object_irq_pending && !ctrl[0].object_irq_pending |-> obj_irq_id == 2'h2)
    else $error("interrupt identifier wrong for object one");

  // invalid object untouched by handler events
  AST_INVALID_IGNORED: assert property (
    !valid[1] && evt.obj == 1'b1 && !ctrl_hit[1] |=> ctrl[1] == $past(ctrl[1]))
    else $error("invalid object changed by handler");

  // short codes of object one decode to themselves
  AST_PAYLOAD_SHORT1: assert property (
    ctrl[1].data_length_code <= can_msg_ctrl_pkg::MAX_BYTES
      |-> payload_bytes[7:4] == ctrl[1].data_length_code)
    else $error("payload count wrong for short length code of object one");

  // long codes of object zero cap at eight
  AST_PAYLOAD_CAP0: assert property (
    ctrl[0].data_length_code > can_msg_ctrl_pkg::MAX_BYTES
      |-> payload_bytes[3:0] == can_msg_ctrl_pkg::MAX_BYTES)
    else $error("payload count not capped at eight for object zero");

  // received length lands in object one as well
  AST_RX_DLC1: assert property (
    evt_hit[1] && evt.rx_data |=> ctrl[1].data_length_code == $past(evt.dlc))
    else $error("received length code not stored in object one");

  // end-of-buffer outputs follow the control fields
  AST_EOB_FLAGS: assert property (
    eob_flags == {ctrl[1].end_of_buffer_flag, ctrl[0].end_of_buffer_flag})
    else $error("end-of-buffer output differs from control field");

  // reception with receive irq enable clear keeps pending as it was
  AST_RX_KEEP_PEND: assert property (
    evt_hit[1] && evt.rx_data && !ctrl[1].receive_irq_enable && !evt.tx_done && !ctrl_hit[1]
      |=> $stable(ctrl[1].object_irq_pending))
    else $error("reception changed pending while disabled");

  // object zero pending always wins the identifier
  AST_IRQ_FIRST: assert property (
    ctrl[0].object_irq_pending |-> obj_irq_id == 2'h1)
    else $error("interrupt identifier wrong for object zero");

  // nothing pending, no identifier
  AST_IRQ_NONE: assert property (
    !ctrl[0].object_irq_pending && !ctrl[1].object_irq_pending |-> obj_irq_id == 2'h0)
    else $error("interrupt identifier set with nothing pending");

  // status rises only for events that reached a valid object
  AST_STS_ONLY_HIT: assert property (
    !(|evt_hit) |=> (sts & ~$past(sts)) == can_msg_ctrl_pkg::EVT_RESET)
    else $error("status bit set by an ignored event");

  // a new event beats a write-one clear of the same bit
  AST_STS_SET_WINS: assert property (
    |sts_set |=> (sts & $past(sts_set)) == $past(sts_set))
    else $error("status event lost");

  // write one clears a status bit when no new event arrives
  AST_STS_CLEAR: assert property (
    wr_take && avs_address == can_msg_ctrl_pkg::IRQ_STATUS_ADDR && avs_byteenable[0]
      && !(|sts_set) |=> (sts & $past(avs_writedata[can_msg_ctrl_pkg::NUM_EVT-1:0]))
      == can_msg_ctrl_pkg::EVT_RESET)
    else $error("status bit not cleared by write one");

  // each request waits exactly one cycle for its answer
  AST_ONE_WAIT: assert property (
    req && !ack |-> avs_waitrequest ##1 (!avs_waitrequest || !req))
    else $error("bus request not answered after one wait cycle");

  // read data answered is the word captured in the wait cycle
  AST_READ_DATA: assert property (
    avs_read && !ack ##1 avs_read |-> avs_readdata == $past(rd_word))
    else $error("read data not the word of the wait cycle");

endmodule

`default_nettype wire

// ===== design/can_msg_ctrl_pkg.sv
// package for the message object control block: register map, field
// positions, reset values, carrier structs and shared field functions.
// assumes a 32-bit avalon-mm byte-addressed register bus.
package can_msg_ctrl_pkg;

  // register byte addresses
  localparam logic [31:0] IF1_CTRL_ADDR = 32'h4005_0038; // interface 1 message control
  localparam logic [31:0] IF2_CTRL_ADDR = 32'h4005_0098; // interface 2 message control
  localparam logic [31:0] VALID_ADDR = 32'h4005_0100; // object valid bits
  localparam logic [31:0] IRQ_STATUS_ADDR = 32'h4005_0104; // sticky event status, w1c
  localparam logic [31:0] IRQ_MASK_ADDR = 32'h4005_0108; // event mask
  localparam logic [31:0] IRQ_ID_ADDR = 32'h4005_010C; // interrupt identifier

  // control word field positions
  localparam int DLC_LSB = 0; // data length code low bit
  localparam int DLC_MSB = 3; // data length code high bit
  localparam int END_BUF_BIT = 7; // end of buffer
  localparam int TX_REQ_BIT = 8; // transmit request
  localparam int REMOTE_EN_BIT = 9; // remote reply enable
  localparam int RX_IRQ_EN_BIT = 10; // receive irq enable
  localparam int TX_IRQ_EN_BIT = 11; // transmit irq enable
  localparam int IRQ_PEND_BIT = 13; // object irq pending

  // sizes and values
  localparam int NUM_OBJ = 2; // objects, one behind each interface register
  localparam int NUM_EVT = 3; // event status bits
  localparam int EVT_RX = 0; // data frame stored
  localparam int EVT_TX = 1; // frame transmitted
  localparam int EVT_RMT = 2; // remote frame answered
  localparam logic [3:0] MAX_BYTES = 4'h8; // largest payload
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000; // reset and unmapped read value
  localparam logic [NUM_OBJ-1:0] VALID_RESET = 2'h0; // objects start invalid
  localparam logic [NUM_EVT-1:0] EVT_RESET = 3'h0; // status and mask reset

  // control fields of one message object
  typedef struct packed {
    logic [3:0] data_length_code; // frame length code
    logic end_of_buffer_flag; // last of a fifo chain or standalone
    logic transmit_request; // transmission pending
    logic remote_reply_enable; // remote frame sets transmit request
    logic receive_irq_enable; // reception sets pending
    logic transmit_irq_enable; // transmission sets pending
    logic object_irq_pending; // object is an interrupt source
  } obj_ctrl_t;

  // events from the message handler
  typedef struct packed {
    logic rx_data; // data frame stored, one-cycle pulse
    logic rx_remote; // matching remote frame received, pulse
    logic tx_done; // frame sent successfully, pulse
    logic obj; // object the event concerns
    logic [3:0] dlc; // length code of the received data frame
  } hnd_evt_t;

  localparam obj_ctrl_t CTRL_RESET = '0; // all control fields clear

  // control fields to bus word, reserved bits zero
  function automatic logic [31:0] ctrl_to_word(obj_ctrl_t c);
    logic [31:0] w;
    w = WORD_ZERO;
    w[DLC_MSB:DLC_LSB] = c.data_length_code;
    w[END_BUF_BIT] = c.end_of_buffer_flag;
    w[TX_REQ_BIT] = c.transmit_request;
    w[REMOTE_EN_BIT] = c.remote_reply_enable;
    w[RX_IRQ_EN_BIT] = c.receive_irq_enable;
    w[TX_IRQ_EN_BIT] = c.transmit_irq_enable;
    w[IRQ_PEND_BIT] = c.object_irq_pending;
    return w;
  endfunction

  // bus word to control fields
  function automatic obj_ctrl_t word_to_ctrl(logic [31:0] w);
    obj_ctrl_t c;
    c.data_length_code = w[DLC_MSB:DLC_LSB];
    c.end_of_buffer_flag = w[END_BUF_BIT];
    c.transmit_request = w[TX_REQ_BIT];
    c.remote_reply_enable = w[REMOTE_EN_BIT];
    c.receive_irq_enable = w[RX_IRQ_EN_BIT];
    c.transmit_irq_enable = w[TX_IRQ_EN_BIT];
    c.object_irq_pending = w[IRQ_PEND_BIT];
    return c;
  endfunction

  // length code to payload bytes, codes above eight mean eight
  function automatic logic [3:0] payload_of(logic [3:0] dlc);
    return (dlc > MAX_BYTES) ? MAX_BYTES : dlc;
  endfunction

endpackage

// ===== testbench/can_msg_ctrl_test.sv
// self-checking testbench for the message object control block.
// assumes can_msg_ctrl_pkg and can_msg_ctrl are compiled before it.
`timescale 1ns/1ns
`default_nettype none

module can_msg_ctrl_test;
  // one expected read result
  typedef struct {
    string name; // register read
    logic [31:0] exp; // expected read data
  } note_t;

  localparam logic [31:0] C0 = can_msg_ctrl_pkg::IF1_CTRL_ADDR; // object 0 control
  localparam logic [31:0] C1 = can_msg_ctrl_pkg::IF2_CTRL_ADDR; // object 1 control
  localparam logic [31:0] VA = can_msg_ctrl_pkg::VALID_ADDR; // valid bits
  localparam logic [31:0] ST = can_msg_ctrl_pkg::IRQ_STATUS_ADDR; // event status
  localparam logic [31:0] MK = can_msg_ctrl_pkg::IRQ_MASK_ADDR; // event mask

  logic clk = 1'h0; // 50 mhz clock
  logic rst_b = 1'h0; // reset, active low
  logic [31:0] avs_address = 32'h0000_0000; // bus address
  logic avs_read = 1'h0; // read request
  logic avs_write = 1'h0; // write request
  logic [31:0] avs_writedata = 32'h0000_0000; // write data
  logic [3:0] avs_byteenable = 4'hF; // write lanes
  logic [31:0] avs_readdata; // read data
  logic avs_waitrequest; // bus stall
  can_msg_ctrl_pkg::hnd_evt_t evt = '0; // handler events
  logic [1:0] tx_pending; // objects waiting to send
  logic [1:0] rx_accept; // objects taking frames
  logic [1:0] eob_flags; // end-of-buffer flags
  logic [7:0] payload_bytes; // byte counts
  logic [1:0] obj_irq_id; // pending object identifier
  logic irq; // level interrupt
  note_t notes[$]; // expected reads, oldest first
  note_t nt; // note being compared
  int num_errors = 0; // mismatches
  int n_compared = 0; // comparisons
  logic [3:0] d; // random length code

  // free-running clock
  always #10 clk = ~clk;

  can_msg_ctrl dut (
    .clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .evt(evt),
    .tx_pending(tx_pending), .rx_accept(rx_accept), .eob_flags(eob_flags),
    .payload_bytes(payload_bytes), .obj_irq_id(obj_irq_id), .irq(irq)
  );

  // control word; f is {pending, transmit_irq_enable, receive_irq_enable, remote, txrq, eob}
  function automatic logic [31:0] cw(input logic [3:0] dl, input logic [5:0] f);
    return {18'h0_0000, f[5], 1'h0, f[4:1], f[0], 3'h0, dl};
  endfunction

  // bytes carried by a length code
  function automatic logic [3:0] pl(input logic [3:0] dl);
    return (dl > 4'h8) ? 4'h8 : dl;
  endfunction

  // compare and count
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one avalon transfer, held until waitrequest is sampled low at a rising edge,
  // released at that edge; returns mid-cycle so outputs have settled
  task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] data,
                     input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= addr;
    avs_writedata <= data;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'h0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n >= 50) begin
      num_errors++;
      $display("ERROR waitrequest expected 0 seen %b", avs_waitrequest);
    end
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    @(negedge clk);
  endtask

  task automatic wr(input logic [31:0] addr, input logic [31:0] data,
                    input logic [3:0] be = 4'hF);
    bus(1'h1, addr, data, be);
  endtask

  // a read notes its expectation for the monitor
  task automatic rd(input logic [31:0] addr, input logic [31:0] exp, input string name);
    notes.push_back('{name, exp});
    bus(1'h0, addr, 32'h0000_0000, 4'hF);
  endtask

  // one handler pulse, then settle one more cycle
  task automatic ev(input logic [2:0] k, input logic ob, input logic [3:0] dl);
    @(posedge clk);
    evt <= '{rx_data: k[2], rx_remote: k[1], tx_done: k[0], obj: ob, dlc: dl};
    @(posedge clk);
    evt <= '0;
    @(posedge clk);
    @(negedge clk);
  endtask

  // monitor: compares read data at the edge where the read is answered
  always @(posedge clk) begin
    if (avs_read === 1'h1 && avs_waitrequest === 1'h0) begin
      if (notes.size() == 0) begin
        check("unexpected read", 32'h0000_0000, 32'hFFFF_FFFF);
      end else begin
        nt = notes.pop_front();
        check(nt.name, nt.exp, avs_readdata);
      end
    end
  end

  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    $display("ERROR watchdog expected done seen running");
    summarize();
  end

  // main sequence
  initial begin
    void'($urandom(66));
    repeat (8) @(posedge clk);
    rst_b <= 1'h1;
    repeat (2) @(posedge clk);
    // reset values, an unmapped place
    rd(C0, 32'h0000_0000, "ctrl0 reset");
    rd(C1, 32'h0000_0000, "ctrl1 reset");
    rd(VA, 32'h0000_0000, "valid reset");
    rd(MK, 32'h0000_0000, "mask reset");
    wr(32'h4005_0110, 32'hFFFF_FFFF);
    rd(32'h4005_0110, 32'h0000_0000, "unmapped");
    // every field set, reserved bits read zero, object still invalid
    wr(C0, 32'hFFFF_FFFF);
    rd(C0, cw(4'hF, 6'h3F), "ctrl0 all");
    check("eob", 32'h1, 32'(eob_flags));
    check("txp invalid", 32'h0, 32'(tx_pending));
    check("bytes 15", 32'h8, 32'(payload_bytes[3:0]));
    // low lane only
    wr(C0, 32'h0000_0000, 4'h1);
    rd(C0, cw(4'h0, 6'h3E), "ctrl0 lane");
    wr(C0, 32'h0000_0000);
    wr(VA, 32'h0000_0003);
    check("accept", 32'h3, 32'(rx_accept));
    // every length code, eob toggling
    for (int i = 0; i < 16; i++) begin
      wr(C0, cw(4'(i), 6'(i % 2)));
      check("bytes", 32'(pl(4'(i))), 32'(payload_bytes[3:0]));
      check("eob0", 32'(i % 2), 32'(eob_flags[0]));
    end
    // reception with receive_irq_enable, random length, unmasked
    wr(MK, 32'h0000_0007);
    wr(C0, cw(4'h0, 6'h08));
    d = 4'($urandom());
    ev(3'h4, 1'h0, d);
    check("bytes rx", 32'(pl(d)), 32'(payload_bytes[3:0]));
    check("irq id", 32'h1, 32'(obj_irq_id));
    check("irq rx", 32'h1, 32'(irq));
    rd(C0, cw(d, 6'h28), "ctrl0 rx");
    rd(ST, 32'h0000_0001, "status rx");
    wr(ST, 32'h0000_0001);
    check("irq cleared", 32'h0, 32'(irq));
    // masked event, receive_irq_enable clear leaves pending alone
    wr(MK, 32'h0000_0006);
    wr(C1, cw(4'h5, 6'h00));
    ev(3'h4, 1'h1, 4'hC);
    check("irq masked", 32'h0, 32'(irq));
    rd(C1, cw(4'hC, 6'h00), "ctrl1 rx no ie");
    check("bytes1", 32'h8, 32'(payload_bytes[7:4]));
    rd(ST, 32'h0000_0001, "status masked");
    wr(ST, 32'h0000_0001);
    // remote frame with reply enabled, then transmission with transmit_irq_enable
    wr(C1, cw(4'h0, 6'h14));
    ev(3'h2, 1'h1, 4'h0);
    check("txp remote", 32'h2, 32'(tx_pending));
    check("irq remote", 32'h1, 32'(irq));
    ev(3'h1, 1'h1, 4'h0);
    check("txp done", 32'h0, 32'(tx_pending));
    rd(C1, cw(4'h0, 6'h34), "ctrl1 tx");
    check("irq id both", 32'h1, 32'(obj_irq_id));
    wr(C0, 32'h0000_0000);
    check("irq id obj1", 32'h2, 32'(obj_irq_id));
    rd(can_msg_ctrl_pkg::IRQ_ID_ADDR, 32'h0000_0002, "irq id reg");
    rd(ST, 32'h0000_0006, "status tx");
    // reply disabled, transmit_irq_enable clear
    wr(C1, cw(4'h0, 6'h00));
    ev(3'h2, 1'h1, 4'h0);
    check("txp no reply", 32'h0, 32'(tx_pending));
    wr(C1, cw(4'h0, 6'h02));
    check("txp sw", 32'h2, 32'(tx_pending));
    ev(3'h1, 1'h1, 4'h0);
    rd(C1, cw(4'h0, 6'h00), "ctrl1 tx no ie");
    // invalid object ignores handler data and remote frames
    wr(VA, 32'h0000_0001);
    check("accept one", 32'h1, 32'(rx_accept));
    wr(C1, cw(4'h3, 6'h1C));
    wr(ST, 32'h0000_0007);
    ev(3'h4, 1'h1, 4'hA);
    ev(3'h2, 1'h1, 4'h0);
    rd(C1, cw(4'h3, 6'h1C), "ctrl1 invalid");
    rd(ST, 32'h0000_0000, "status invalid");
    repeat (2) @(posedge clk);
    summarize();
  end
endmodule

`default_nettype wire
